// ==== include/pi_check_pkg.sv ====
package pi_check_pkg;
  // Completion status codes
  typedef enum logic [2:0] {
    ST_SUCCESS = 3'b000,
    ST_GUARD = 3'b001,
    ST_APP_TAG = 3'b010,
    ST_REF_TAG = 3'b011,
    ST_INVALID_PI = 3'b100,
    ST_INVALID_FIELD = 3'b101
  } status_type;
  // Namespace protection types
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_TYPE1 = 2'h1;
  localparam logic [1:0] PROT_TYPE2 = 2'h2;
  localparam logic [1:0] PROT_TYPE3 = 2'h3;
  // Check select field bit positions
  localparam int CHK_REF_BIT = 0;
  localparam int CHK_APP_BIT = 1;
  localparam int CHK_GUARD_BIT = 2;
  // Guard CRC
  localparam logic [15:0] CRC_POLY = 16'h8bb7;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Escape values
  localparam logic [15:0] APP_ESCAPE = 16'hffff;
  localparam logic [31:0] REF_ESCAPE = 32'hffffffff;
  // Protection information layout, byte index of the last byte
  localparam logic [2:0] PI_LAST_IDX = 3'h7;
endpackage : pi_check_pkg

// ==== hdl/block_protection_info_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module block_protection_info_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CMD_START,
  input wire logic CMD_IS_WRITE,
  input wire logic [2:0] CHECK_SELECT_FIELD,
  input wire logic [15:0] EXPECTED_APP_TAG,
  input wire logic [15:0] APP_TAG_MASK,
  input wire logic [31:0] INITIAL_REF_TAG,
  input wire logic [31:0] EXPECTED_INITIAL_REF_TAG,
  input wire logic [31:0] START_LBA_LOW,
  input wire logic [1:0] PROT_TYPE,
  input wire logic INSERT_STRIP_ACTION,
  input wire logic PI_FIRST,
  input wire logic META_EXTRA,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_PI,
  input wire logic IN_META,
  input wire logic IN_BLOCK_LAST,
  input wire logic IN_CMD_LAST,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [7:0] OUT_DATA,
  output logic OUT_PI,
  output logic OUT_BLOCK_LAST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic BUSY,
  output logic DONE,
  output logic [2:0] STATUS
);
  ////////////////////////////////////////////////////////////////////////////////
  // CRC byte update
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ pi_check_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte

  ////////////////////////////////////////////////////////////////////////////////
  // Command and stream state
  logic busy_ff, nxt_busy;
  logic is_write_ff, nxt_is_write;
  logic [2:0] chk_ff, nxt_chk;
  logic [15:0] app_ff, nxt_app;
  logic [15:0] mask_ff, nxt_mask;
  logic [1:0] type_ff, nxt_type;
  logic action_ff, nxt_action;
  logic pi_first_ff, nxt_pi_first;
  logic extra_ff, nxt_extra;
  logic [31:0] ref_ff, nxt_ref;
  logic [15:0] crc_ff, nxt_crc;
  logic [2:0] idx_ff, nxt_idx;
  logic [55:0] pi_ff, nxt_pi;
  pi_check_pkg::status_type status_ff, nxt_status;
  logic done_ff, nxt_done;
  logic [2:0] status_out_ff, nxt_status_out;

  logic in_ready_ff;
  logic accept, insert_mode, strip_mode, check_mode, push, pi_done, disabled;
  logic [63:0] pi_word, ins_word;
  logic [7:0] push_data;
  logic guard_bad, app_bad, ref_bad, blk_end, cmd_end, start_ok;

  always_comb begin
    start_ok = CMD_START && !busy_ff;
    accept = IN_VALID && in_ready_ff && busy_ff;
    insert_mode = is_write_ff && action_ff && (type_ff != pi_check_pkg::PROT_NONE);
    strip_mode = !is_write_ff && action_ff && !extra_ff
      && (type_ff != pi_check_pkg::PROT_NONE);
    check_mode = (type_ff != pi_check_pkg::PROT_NONE) && !insert_mode;
    pi_word = {pi_ff, IN_DATA};
    ins_word = {crc_ff, app_ff, ref_ff};
    pi_done = accept && IN_PI && (idx_ff == pi_check_pkg::PI_LAST_IDX);
    if (type_ff == pi_check_pkg::PROT_TYPE3) begin
      disabled = (pi_word[47:32] == pi_check_pkg::APP_ESCAPE)
        && (pi_word[31:0] == pi_check_pkg::REF_ESCAPE);
    end else begin
      disabled = (pi_word[47:32] == pi_check_pkg::APP_ESCAPE);
    end
    guard_bad = chk_ff[pi_check_pkg::CHK_GUARD_BIT] && (pi_word[63:48] != crc_ff);
    app_bad = chk_ff[pi_check_pkg::CHK_APP_BIT]
      && (((pi_word[47:32] ^ app_ff) & mask_ff) != 16'h0000);
    ref_bad = chk_ff[pi_check_pkg::CHK_REF_BIT] && (type_ff != pi_check_pkg::PROT_TYPE3)
      && (pi_word[31:0] != ref_ff);
    blk_end = accept && IN_BLOCK_LAST;
    cmd_end = blk_end && IN_CMD_LAST;
    push = accept && !(strip_mode && IN_PI);
    push_data = (insert_mode && IN_PI) ? ins_word[8'(7 - idx_ff) * 8 +: 8] : IN_DATA;
  end

  always_comb begin
    nxt_busy = busy_ff;
    nxt_is_write = is_write_ff;
    nxt_chk = chk_ff;
    nxt_app = app_ff;
    nxt_mask = mask_ff;
    nxt_type = type_ff;
    nxt_action = action_ff;
    nxt_pi_first = pi_first_ff;
    nxt_extra = extra_ff;
    nxt_ref = ref_ff;
    nxt_crc = crc_ff;
    nxt_idx = idx_ff;
    nxt_pi = pi_ff;
    nxt_status = status_ff;
    nxt_done = 1'b0;
    nxt_status_out = status_out_ff;
    if (start_ok) begin
      nxt_busy = 1'b1;
      nxt_is_write = CMD_IS_WRITE;
      nxt_chk = CHECK_SELECT_FIELD;
      nxt_app = EXPECTED_APP_TAG;
      nxt_mask = APP_TAG_MASK;
      nxt_type = PROT_TYPE;
      nxt_action = INSERT_STRIP_ACTION;
      nxt_pi_first = PI_FIRST;
      nxt_extra = META_EXTRA;
      nxt_ref = CMD_IS_WRITE ? INITIAL_REF_TAG : EXPECTED_INITIAL_REF_TAG;
      nxt_crc = pi_check_pkg::CRC_INIT;
      nxt_idx = 3'h0;
      nxt_status = pi_check_pkg::ST_SUCCESS;
      if (PROT_TYPE == pi_check_pkg::PROT_TYPE1 && nxt_ref != START_LBA_LOW) begin
        nxt_status = pi_check_pkg::ST_INVALID_PI;
      end else if (PROT_TYPE == pi_check_pkg::PROT_TYPE3
          && CHECK_SELECT_FIELD[pi_check_pkg::CHK_REF_BIT]) begin
        nxt_status = pi_check_pkg::ST_INVALID_FIELD;
      end
    end else if (accept) begin
      if (IN_PI) begin
        nxt_idx = idx_ff + 3'h1;
        nxt_pi = pi_word[55:0];
      end else if (!(IN_META && pi_first_ff)) begin
        nxt_crc = crc_byte(crc_ff, IN_DATA);
      end
      if (pi_done && check_mode && !disabled && status_ff == pi_check_pkg::ST_SUCCESS) begin
        if (guard_bad) begin
          nxt_status = pi_check_pkg::ST_GUARD;
        end else if (app_bad) begin
          nxt_status = pi_check_pkg::ST_APP_TAG;
        end else if (ref_bad) begin
          nxt_status = pi_check_pkg::ST_REF_TAG;
        end
      end
      if (blk_end) begin
        nxt_crc = pi_check_pkg::CRC_INIT;
        nxt_idx = 3'h0;
        if (type_ff != pi_check_pkg::PROT_TYPE3) begin
          nxt_ref = ref_ff + 32'h00000001;
        end
      end
      if (cmd_end) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_status_out = nxt_status;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      busy_ff <= 1'b0;
      is_write_ff <= 1'b0;
      chk_ff <= 3'h0;
      app_ff <= 16'h0000;
      mask_ff <= 16'h0000;
      type_ff <= pi_check_pkg::PROT_NONE;
      action_ff <= 1'b0;
      pi_first_ff <= 1'b0;
      extra_ff <= 1'b0;
      ref_ff <= 32'h00000000;
      crc_ff <= pi_check_pkg::CRC_INIT;
      idx_ff <= 3'h0;
      pi_ff <= 56'h0;
      status_ff <= pi_check_pkg::ST_SUCCESS;
      done_ff <= 1'b0;
      status_out_ff <= 3'h0;
    end else begin
      busy_ff <= nxt_busy;
      is_write_ff <= nxt_is_write;
      chk_ff <= nxt_chk;
      app_ff <= nxt_app;
      mask_ff <= nxt_mask;
      type_ff <= nxt_type;
      action_ff <= nxt_action;
      pi_first_ff <= nxt_pi_first;
      extra_ff <= nxt_extra;
      ref_ff <= nxt_ref;
      crc_ff <= nxt_crc;
      idx_ff <= nxt_idx;
      pi_ff <= nxt_pi;
      status_ff <= nxt_status;
      done_ff <= nxt_done;
      status_out_ff <= nxt_status_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  logic out_valid_ff, nxt_out_valid, skid_valid_ff, nxt_skid_valid;
  logic [9:0] out_ff, nxt_out, skid_ff, nxt_skid;
  logic [9:0] push_word;

  always_comb begin
    push_word = {IN_PI, IN_BLOCK_LAST, push_data};
    nxt_out_valid = out_valid_ff;
    nxt_out = out_ff;
    nxt_skid_valid = skid_valid_ff;
    nxt_skid = skid_ff;
    if (!out_valid_ff || OUT_READY) begin
      if (skid_valid_ff) begin
        nxt_out = skid_ff;
        nxt_out_valid = 1'b1;
        nxt_skid_valid = 1'b0;
      end else begin
        nxt_out = push_word;
        nxt_out_valid = push;
      end
    end else if (push) begin
      nxt_skid = push_word;
      nxt_skid_valid = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      out_valid_ff <= 1'b0;
      out_ff <= 10'h000;
      skid_valid_ff <= 1'b0;
      skid_ff <= 10'h000;
      in_ready_ff <= 1'b0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_ff <= nxt_out;
      skid_valid_ff <= nxt_skid_valid;
      skid_ff <= nxt_skid;
      in_ready_ff <= !nxt_skid_valid;
    end
  end

  assign IN_READY = in_ready_ff;
  assign OUT_VALID = out_valid_ff;
  assign OUT_DATA = out_ff[7:0];
  assign OUT_BLOCK_LAST = out_ff[8];
  assign OUT_PI = out_ff[9];
  assign BUSY = busy_ff;
  assign DONE = done_ff;
  assign STATUS = status_out_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_init_pi;
    @(posedge CLOCK) disable iff (RST)
      start_ok && PROT_TYPE == pi_check_pkg::PROT_TYPE1 && CMD_IS_WRITE
      && INITIAL_REF_TAG != START_LBA_LOW |=> status_ff == pi_check_pkg::ST_INVALID_PI;
  endproperty
  a_init_pi: assert property (p_init_pi) else $error("Bad initial ref not flagged");
  property p_type3_field;
    @(posedge CLOCK) disable iff (RST)
      start_ok && PROT_TYPE == pi_check_pkg::PROT_TYPE3 && CHECK_SELECT_FIELD[0]
      |=> status_ff == pi_check_pkg::ST_INVALID_FIELD;
  endproperty
  a_type3_field: assert property (p_type3_field) else $error("Type 3 ref check kept");
  property p_ref_load;
    @(posedge CLOCK) disable iff (RST)
      start_ok && !CMD_IS_WRITE |=> ref_ff == $past(EXPECTED_INITIAL_REF_TAG);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("Initial ref not loaded");
  property p_ref_inc;
    @(posedge CLOCK) disable iff (RST)
      blk_end && type_ff != pi_check_pkg::PROT_TYPE3 |=> ref_ff == $past(ref_ff) + 32'h1;
  endproperty
  a_ref_inc: assert property (p_ref_inc) else $error("Ref tag not incremented");
  property p_ref_hold;
    @(posedge CLOCK) disable iff (RST)
      blk_end && type_ff == pi_check_pkg::PROT_TYPE3 |=> $stable(ref_ff);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("Type 3 ref tag moved");
  property p_strip;
    @(posedge CLOCK) disable iff (RST)
      accept && IN_PI && strip_mode && !out_valid_ff && !skid_valid_ff |=> !OUT_VALID;
  endproperty
  a_strip: assert property (p_strip) else $error("PI byte not stripped");
  property p_guard;
    @(posedge CLOCK) disable iff (RST)
      pi_done && check_mode && !disabled && guard_bad && status_ff == 3'h0
      |=> status_ff == pi_check_pkg::ST_GUARD;
  endproperty
  a_guard: assert property (p_guard) else $error("Guard error not recorded");
  property p_escape;
    @(posedge CLOCK) disable iff (RST)
      pi_done && disabled && status_ff == 3'h0 |=> status_ff == pi_check_pkg::ST_SUCCESS;
  endproperty
  a_escape: assert property (p_escape) else $error("Escape did not disable checks");
  property p_done;
    @(posedge CLOCK) disable iff (RST)
      cmd_end |=> DONE && STATUS == $past(nxt_status) ##1 !DONE;
  endproperty
  a_done: assert property (p_done) else $error("Completion not reported");
  property p_hold;
    @(posedge CLOCK) disable iff (RST)
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("Output lost under stall");
  c_done: cover property (@(posedge CLOCK) disable iff (RST) DONE);
  c_guard: cover property (@(posedge CLOCK) disable iff (RST) DONE && STATUS == 3'h1);
  c_insert: cover property (@(posedge CLOCK) disable iff (RST) accept && insert_mode && IN_PI);
  c_strip: cover property (@(posedge CLOCK) disable iff (RST) accept && strip_mode && IN_PI);
endmodule : block_protection_info_checker
`default_nettype wire

// ==== bench/pi_stream_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
// Receiving side of the block output stream, able to answer promptly or slowly
module pi_stream_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic [7:0] data,
  input wire logic pi,
  input wire logic last,
  input wire logic valid,
  output logic ready
);
  logic [9:0] q[$];
  logic [1:0] cnt_ff;
  // A word is taken only on an edge with valid and ready both high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      if (valid && ready) begin
        q.push_back({pi, last, data});
      end
    end
  end
  // Slow mode holds ready low three cycles of four
  assign ready = !rst && (!stall || cnt_ff == 2'h3);
endmodule : pi_stream_sink
`default_nettype wire

// ==== bench/block_protection_info_checker_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module block_protection_info_checker_test;
  typedef struct {
    logic [1:0] pt;
    logic [2:0] chk;
    logic [15:0] mask, app;
    logic [31:0] init;
    logic lbad, gbad, rbad;
    pi_check_pkg::status_type st;
  } row_type;
  logic CLOCK, RST, CMD_START, CMD_IS_WRITE, INSERT_STRIP_ACTION, PI_FIRST, META_EXTRA;
  logic [2:0] CHECK_SELECT_FIELD, STATUS;
  logic [15:0] EXPECTED_APP_TAG, APP_TAG_MASK;
  logic [31:0] INITIAL_REF_TAG, EXPECTED_INITIAL_REF_TAG, START_LBA_LOW;
  logic [1:0] PROT_TYPE;
  logic [7:0] IN_DATA, OUT_DATA;
  logic IN_PI, IN_META, IN_BLOCK_LAST, IN_CMD_LAST, IN_VALID, IN_READY, stall;
  logic OUT_PI, OUT_BLOCK_LAST, OUT_VALID, OUT_READY, BUSY, DONE;
  logic [11:0] in_q[$];
  logic [9:0] exp_q[$];
  int mismatches = 0;
  int n_checks = 0;
  row_type rows[14] = '{
    '{0, 7, 16'hffff, 16'h1234, 32'h100, 0, 1, 1, pi_check_pkg::ST_SUCCESS},
    '{1, 7, 16'hffff, 16'h1234, 32'h100, 0, 0, 0, pi_check_pkg::ST_SUCCESS},
    '{1, 4, 16'hffff, 16'h1234, 32'h100, 0, 1, 0, pi_check_pkg::ST_GUARD},
    '{1, 3, 16'hffff, 16'h1234, 32'h100, 0, 1, 0, pi_check_pkg::ST_SUCCESS},
    '{1, 2, 16'h00ff, 16'h5634, 32'h100, 0, 0, 0, pi_check_pkg::ST_SUCCESS},
    '{1, 2, 16'hffff, 16'h1235, 32'h100, 0, 0, 0, pi_check_pkg::ST_APP_TAG},
    '{1, 1, 16'hffff, 16'h1234, 32'h100, 0, 0, 1, pi_check_pkg::ST_REF_TAG},
    '{1, 0, 16'hffff, 16'h1234, 32'h100, 1, 0, 0, pi_check_pkg::ST_INVALID_PI},
    '{2, 7, 16'hffff, 16'h1234, 32'hffffffff, 1, 0, 0, pi_check_pkg::ST_SUCCESS},
    '{3, 1, 16'hffff, 16'h1234, 32'h5, 0, 0, 0, pi_check_pkg::ST_INVALID_FIELD},
    '{3, 6, 16'hffff, 16'h1234, 32'h5, 0, 0, 0, pi_check_pkg::ST_SUCCESS},
    '{1, 7, 16'hffff, 16'hffff, 32'h100, 0, 1, 1, pi_check_pkg::ST_SUCCESS},
    '{3, 6, 16'hffff, 16'hffff, 32'hffffffff, 0, 1, 0, pi_check_pkg::ST_SUCCESS},
    '{3, 6, 16'hffff, 16'hffff, 32'h5, 0, 1, 0, pi_check_pkg::ST_GUARD}
  };
  block_protection_info_checker uut (.CLOCK, .RST, .CMD_START, .CMD_IS_WRITE,
    .CHECK_SELECT_FIELD, .EXPECTED_APP_TAG, .APP_TAG_MASK, .INITIAL_REF_TAG,
    .EXPECTED_INITIAL_REF_TAG, .START_LBA_LOW, .PROT_TYPE, .INSERT_STRIP_ACTION, .PI_FIRST,
    .META_EXTRA, .IN_DATA, .IN_PI, .IN_META, .IN_BLOCK_LAST, .IN_CMD_LAST, .IN_VALID,
    .IN_READY, .OUT_DATA, .OUT_PI, .OUT_BLOCK_LAST, .OUT_VALID, .OUT_READY, .BUSY, .DONE,
    .STATUS);
  pi_stream_sink sink (.clock(CLOCK), .rst(RST), .stall(stall), .data(OUT_DATA),
    .pi(OUT_PI), .last(OUT_BLOCK_LAST), .valid(OUT_VALID), .ready(OUT_READY));
////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang();
    mismatches++;
    $display("[ERR] wait bound used up");
    end_sim();
  endtask : hang
  // Guard CRC, one byte, most significant bit first
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h8bb7 : {c[14:0], 1'b0};
    return c;
  endfunction : crc8
  // Two blocks: four data bytes, then optional metadata and the protection bytes, the protection bytes first when pf is set
  task automatic build(input row_type c, input logic wr, act, extra, pf, input logic [1:0] nm);
    logic [15:0] g;
    logic [31:0] rf;
    logic [63:0] pi, po;
    logic [7:0] d;
    logic [11:0] w;
    logic [11:0] mq[$];
    logic ins, strip, lst, plast;
    ins = wr & act & (c.pt != 2'h0);
    strip = !wr & act & !extra & (c.pt != 2'h0);
    in_q.delete();
    exp_q.delete();
    for (int b = 0; b < 2; b++) begin
      g = 16'h0000;
      mq.delete();
      for (int i = 0; i < 4 + nm; i++) begin
        d = 8'(64 * b + 29 * i + 7);
        lst = pf && i >= 4 && i == 3 + nm;
        w = {1'b0, i >= 4, lst, lst && b == 1, d};
        if (i < 4 || !pf) begin
          g = crc8(g, d);
          in_q.push_back(w);
          exp_q.push_back({1'b0, lst, d});
        end else begin
          mq.push_back(w);
        end
      end
      rf = (c.pt == 2'h3 || (c.rbad && b == 1)) ? c.init : c.init + 32'(b);
      pi = {g ^ {15'h0, c.gbad}, c.app, rf};
      po = ins ? {g, 16'h1234, rf} : pi;
      if (ins) pi = ~pi;
      for (int k = 7; k >= 0; k--) begin
        plast = k == 0 && mq.size() == 0;
        in_q.push_back({1'b1, 1'b0, plast, b == 1 && plast, pi[8 * k +: 8]});
        if (!strip) exp_q.push_back({1'b1, plast, po[8 * k +: 8]});
      end
      foreach (mq[j]) begin
        in_q.push_back(mq[j]);
        exp_q.push_back({1'b0, mq[j][9], mq[j][7:0]});
      end
    end
  endtask : build
  task automatic run_cmd(input row_type c, input logic wr, act, extra, pf,
      input logic [1:0] nm);
    logic rdy;
    int n;
    build(c, wr, act, extra, pf, nm);
    sink.q.delete();
    @(posedge CLOCK);
    CMD_START <= 1'b1;
    CMD_IS_WRITE <= wr;
    INSERT_STRIP_ACTION <= act;
    META_EXTRA <= extra;
    PI_FIRST <= pf;
    PROT_TYPE <= c.pt;
    CHECK_SELECT_FIELD <= c.chk;
    APP_TAG_MASK <= c.mask;
    INITIAL_REF_TAG <= wr ? c.init : ~c.init;
    EXPECTED_INITIAL_REF_TAG <= wr ? ~c.init : c.init;
    START_LBA_LOW <= c.init ^ {31'h0, c.lbad};
    @(posedge CLOCK);
    CMD_START <= 1'b0;
    foreach (in_q[j]) begin
      {IN_PI, IN_META, IN_BLOCK_LAST, IN_CMD_LAST, IN_DATA} <= in_q[j];
      IN_VALID <= 1'b1;
      n = 0;
      do begin
        @(negedge CLOCK);
        rdy = IN_READY;
        @(posedge CLOCK);
        n++;
      end while (!rdy && n < 200);
      if (!rdy) hang();
    end
    IN_VALID <= 1'b0;
    n = 0;
    do begin
      @(negedge CLOCK);
      n++;
    end while (DONE !== 1'b1 && n < 50);
    if (DONE !== 1'b1) hang();
    chk("status", STATUS, c.st);
    chk("busy", BUSY, 0);
    n = 0;
    while (sink.q.size() < exp_q.size() && n < 300) begin
      @(negedge CLOCK);
      n++;
    end
    chk("count", sink.q.size(), exp_q.size());
    foreach (exp_q[k]) chk("byte", sink.q[k], exp_q[k]);
  endtask : run_cmd
////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    RST = 1'b1;
    stall = 1'b0;
    EXPECTED_APP_TAG = 16'h1234;
    {CMD_START, CMD_IS_WRITE, INSERT_STRIP_ACTION, PI_FIRST, META_EXTRA, PROT_TYPE} = '0;
    {CHECK_SELECT_FIELD, APP_TAG_MASK, INITIAL_REF_TAG, EXPECTED_INITIAL_REF_TAG} = '0;
    {START_LBA_LOW, IN_DATA, IN_PI, IN_META, IN_BLOCK_LAST, IN_CMD_LAST, IN_VALID} = '0;
    repeat (12) @(posedge CLOCK);
    chk("reset outputs", {IN_READY, BUSY, DONE, OUT_VALID}, 0);
    RST <= 1'b0;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("ready after reset", IN_READY, 1);
    $display("reset test done");
    foreach (rows[i]) begin
      stall <= i[0];
      run_cmd(rows[i], i[1], 0, 0, 0, 0);
      $display("row %0d done", i);
    end
    stall <= 1'b1;
    run_cmd('{1, 7, 16'hffff, 16'h0, 32'h20, 0, 0, 0, pi_check_pkg::ST_SUCCESS}, 1, 1, 0, 0, 0);
    $display("insert test done");
    run_cmd(rows[8], 0, 1, 0, 0, 0);
    $display("strip test done");
    run_cmd(rows[1], 0, 1, 1, 0, 2);
    $display("metadata test done");
    run_cmd(rows[1], 0, 1, 1, 1, 2);
    $display("pi first test done");
    @(posedge CLOCK);
    CMD_START <= 1'b1;
    @(posedge CLOCK);
    CMD_START <= 1'b0;
    {IN_PI, IN_META, IN_BLOCK_LAST, IN_CMD_LAST, IN_DATA} <= 12'h0a5;
    IN_VALID <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b1;
    @(negedge CLOCK);
    chk("mid reset outputs", {IN_READY, BUSY, DONE, OUT_VALID, STATUS}, 0);
    @(posedge CLOCK);
    IN_VALID <= 1'b0;
    RST <= 1'b0;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("ready after mid reset", {IN_READY, BUSY, OUT_VALID}, 4);
    run_cmd(rows[2], 0, 0, 0, 0, 0);
    $display("mid reset test done");
    end_sim();
  end
endmodule : block_protection_info_checker_test
`default_nettype wire
